// *** design/clk_in_sync.sv ***
`timescale 1ns/1ps
module clk_in_sync #(
    parameter int W = 2
) (
    // Clock and reset.
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Foreign-domain levels.
    input  wire logic [W-1:0] async_in,
    // Synchronised edges.
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] last_ff;

    // Two flops before any logic; the edge detector compares the second with a third, delayed copy of it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // Edge pulses, one aclk cycle each.
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;

endmodule : clk_in_sync

// *** design/main_osc_pll_clock_gen.sv ***
`timescale 1ns/1ps
`include "clk_gen_defs.svh"
module main_osc_pll_clock_gen #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address.
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data.
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response.
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address.
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data.
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Clocks sampled from outside.
    input  wire logic              slow_clk,
    input  wire logic              main_osc_clk,
    // Oscillator and PLL controls.
    output logic                   main_osc_enable_pin,
    output logic                   osc_bypass_pin,
    output logic [7:0]             pll_prescale_out,
    output logic [10:0]            pll_gain_out,
    output logic                   pll_clk_enable,
    output logic                   main_clk_select,
    // Interrupt.
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [1:0] clk_rise;
    logic [1:0] clk_fall;

    // Both foreign clocks are resynchronised before the counters see them.
    clk_in_sync #(
        .W (2)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({main_osc_clk, slow_clk}),
        .rise     (clk_rise),
        .fall     (clk_fall)
    );

    wire slow_rise = clk_rise[0];
    wire slow_fall = clk_fall[0];
    wire main_rise = clk_rise[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Register state

    logic                       awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic                       aw_hold_ff, w_hold_ff;
    logic [ADDR_W-1:0]          aw_addr_ff;
    logic [31:0]                w_data_ff;
    logic [3:0]                 w_strb_ff;
    logic [1:0]                 bresp_ff, rresp_ff;
    logic [31:0]                rdata_ff;
    logic                       osc_en_ff, osc_byp_ff, osc_run_ff, stable_ff;
    clk_gen_pkg::osc_count_t    osc_cnt_ff, osc_load_ff;
    logic [2:0]                 osc_pre_ff;
    clk_gen_pkg::freq_st_e      freq_st_ff, nxt_freq_st;
    clk_gen_pkg::freq_count_t   freq_cnt_ff;
    logic [4:0]                 fall_cnt_ff;
    clk_gen_pkg::pll_div_t      div_ff;
    clk_gen_pkg::pll_gain_t     gain_ff;
    clk_gen_pkg::pll_settle_t   settle_ff, pll_cnt_ff;
    logic                       pll_busy_ff, lock_ff;
    clk_gen_pkg::irq_vec_t      irq_stat_ff, irq_mask_ff, prev_flag_ff;
    logic                       irq_ff, pll_en_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and merge

    // A write completes once both halves are held; order of arrival is free.
    wire        wr_fire  = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    wire [7:0]  wr_addr  = aw_addr_ff[7:0];
    wire [7:0]  rd_addr  = araddr[7:0];
    wire [31:0] wmask    = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                            {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wire        wr_mor   = wr_fire & (wr_addr == `OFS_OSC_CTRL);
    wire        wr_pll   = wr_fire & (wr_addr == `OFS_PLL_CFG);
    wire        wr_istat = wr_fire & (wr_addr == `OFS_IRQ_STAT);
    wire        wr_imask = wr_fire & (wr_addr == `OFS_IRQ_MASK);
    wire        wr_ok    = wr_mor | wr_pll | wr_istat | wr_imask |
                           (wr_addr == `OFS_FREQ_MEAS) | (wr_addr == `OFS_PWR_STATUS);

    // Current register images, used for reads; the control and PLL images also for byte merging.
    wire [31:0] mor_img  = {16'h0000, osc_load_ff, 6'h00, osc_byp_ff, osc_en_ff};
    wire [31:0] mcf_img  = {15'h0000, freq_st_ff == clk_gen_pkg::FQ_DONE, freq_cnt_ff};
    wire [31:0] pll_img  = {5'h00, gain_ff, 2'h0, settle_ff, div_ff};
    wire [31:0] sr_img   = {29'h0, freq_st_ff == clk_gen_pkg::FQ_DONE, lock_ff, stable_ff};
    wire [31:0] mor_new  = (mor_img & ~wmask) | (w_data_ff & wmask);
    wire [31:0] pll_new  = (pll_img & ~wmask) | (w_data_ff & wmask);
    wire [2:0]  w1c_bits = w_data_ff[2:0] & wmask[2:0];

    wire                     new_en     = mor_new[`OSC_EN_BIT];
    wire                     new_byp    = mor_new[`OSC_BYP_BIT];
    wire [7:0]               new_ocnt   = mor_new[`OSC_CNT_LSB +: 8];
    wire [7:0]               new_div    = pll_new[`PLL_DIV_LSB +: 8];
    wire [5:0]               new_settle = pll_new[`PLL_SETTLE_LSB +: 6];
    wire [10:0]              new_gain   = pll_new[`PLL_GAIN_LSB +: 11];
    wire                     pll_change = wr_pll & (pll_new != pll_img);

    // Read selection; unmapped addresses read zero with a slave error.
    wire        rd_ok    = (rd_addr == `OFS_OSC_CTRL)   | (rd_addr == `OFS_FREQ_MEAS) |
                           (rd_addr == `OFS_PLL_CFG)    | (rd_addr == `OFS_PWR_STATUS) |
                           (rd_addr == `OFS_IRQ_STAT)   | (rd_addr == `OFS_IRQ_MASK);
    wire [31:0] rd_mux   = (rd_addr == `OFS_OSC_CTRL)   ? mor_img :
                           (rd_addr == `OFS_FREQ_MEAS)  ? mcf_img :
                           (rd_addr == `OFS_PLL_CFG)    ? pll_img :
                           (rd_addr == `OFS_PWR_STATUS) ? sr_img  :
                           (rd_addr == `OFS_IRQ_STAT)   ? {29'h0, irq_stat_ff} :
                           (rd_addr == `OFS_IRQ_MASK)   ? {29'h0, irq_mask_ff} :
                           `RST_ZERO_WORD;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    // Each half is taken once and held; readies return after the response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff  <= `RST_ZERO_WORD;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `AXI_RESP_OKAY;
        end else begin
            if (awvalid & awready_ff) begin
                aw_addr_ff <= awaddr;
                aw_hold_ff <= 1'b1;
                awready_ff <= 1'b0;
            end
            if (wvalid & wready_ff) begin
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
                w_hold_ff <= 1'b1;
                wready_ff <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
            if (bvalid_ff & bready) begin
                bvalid_ff  <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    // Data is captured on the address handshake and shown one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= `RST_ZERO_WORD;
            rresp_ff   <= `AXI_RESP_OKAY;
        end else if (arvalid & arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux;
            rresp_ff   <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rvalid_ff & rready) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main oscillator start-up

    // Counts down once per eight slow_clk periods; bypass alone starts no count and never sets stable.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_en_ff   <= 1'b0;
            osc_byp_ff  <= 1'b0;
            osc_load_ff <= 8'h00;
            osc_run_ff  <= 1'b0;
            osc_cnt_ff  <= 8'h00;
            osc_pre_ff  <= 3'h0;
            stable_ff   <= 1'b0;
        end else if (wr_mor) begin
            osc_en_ff   <= new_en;
            osc_byp_ff  <= new_byp;
            osc_load_ff <= new_ocnt;
            stable_ff   <= 1'b0;
            osc_run_ff  <= new_en;
            osc_cnt_ff  <= new_ocnt;
            osc_pre_ff  <= 3'h0;
        end else if (osc_run_ff) begin
            if (osc_cnt_ff == 8'h00) begin
                stable_ff  <= 1'b1;
                osc_run_ff <= 1'b0;
            end else if (slow_rise) begin
                osc_pre_ff <= osc_pre_ff + 3'h1;
                if (osc_pre_ff == `OSC_PRESCALE_MAX) begin
                    osc_cnt_ff <= osc_cnt_ff - 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main clock frequency measurement

    // One measurement per stable period; losing stability starts it over.
    always_comb begin
        nxt_freq_st = freq_st_ff;
        case (freq_st_ff)
            clk_gen_pkg::FQ_IDLE:  if (stable_ff) nxt_freq_st = clk_gen_pkg::FQ_ARM;
            clk_gen_pkg::FQ_ARM:   if (slow_rise) nxt_freq_st = clk_gen_pkg::FQ_COUNT;
            clk_gen_pkg::FQ_COUNT: begin
                if (slow_fall && fall_cnt_ff == `FREQ_LAST_FALL) begin
                    nxt_freq_st = clk_gen_pkg::FQ_DONE;
                end
            end
            clk_gen_pkg::FQ_DONE:  nxt_freq_st = clk_gen_pkg::FQ_DONE;
            default:               nxt_freq_st = clk_gen_pkg::FQ_IDLE;
        endcase
        if (!stable_ff) begin
            nxt_freq_st = clk_gen_pkg::FQ_IDLE;
        end
    end

    // The count is kept after the stop so software can read it at leisure.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_st_ff  <= clk_gen_pkg::FQ_IDLE;
            freq_cnt_ff <= 16'h0000;
            fall_cnt_ff <= 5'h00;
        end else begin
            freq_st_ff <= nxt_freq_st;
            if (freq_st_ff == clk_gen_pkg::FQ_ARM) begin
                freq_cnt_ff <= 16'h0000;
                fall_cnt_ff <= 5'h00;
            end else if (freq_st_ff == clk_gen_pkg::FQ_COUNT) begin
                if (main_rise) begin
                    freq_cnt_ff <= freq_cnt_ff + 16'h0001;
                end
                if (slow_fall) begin
                    fall_cnt_ff <= fall_cnt_ff + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL divider, multiplier and settle counter

    // Any real change restarts settling; rewriting identical values does not.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff      <= 8'h00;
            gain_ff     <= 11'h000;
            settle_ff   <= 6'h00;
            pll_cnt_ff  <= 6'h00;
            pll_busy_ff <= 1'b0;
            lock_ff     <= 1'b0;
            pll_en_ff   <= 1'b0;
        end else begin
            pll_en_ff <= (div_ff != 8'h00) & (gain_ff != 11'h000);
            if (pll_change) begin
                div_ff      <= new_div;
                gain_ff     <= new_gain;
                settle_ff   <= new_settle;
                lock_ff     <= 1'b0;
                pll_cnt_ff  <= new_settle;
                pll_busy_ff <= 1'b1;
            end else if (pll_busy_ff) begin
                if (pll_cnt_ff == 6'h00) begin
                    lock_ff     <= (gain_ff != 11'h000) & (div_ff != 8'h00);
                    pll_busy_ff <= 1'b0;
                end else if (slow_rise) begin
                    pll_cnt_ff <= pll_cnt_ff - 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Rising flags are events; a set in the clearing cycle wins over the clear.
    wire [2:0] cur_flag = {freq_st_ff == clk_gen_pkg::FQ_DONE, lock_ff, stable_ff};
    wire [2:0] evt      = cur_flag & ~prev_flag_ff;
    wire [2:0] nxt_stat = (irq_stat_ff & ~(wr_istat ? w1c_bits : 3'h0)) | evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_flag_ff <= 3'h0;
            irq_stat_ff  <= 3'h0;
            irq_mask_ff  <= 3'h0;
            irq_ff       <= 1'b0;
        end else begin
            prev_flag_ff <= cur_flag;
            irq_stat_ff  <= nxt_stat;
            if (wr_imask) begin
                irq_mask_ff <= (irq_mask_ff & ~wmask[2:0]) | (w_data_ff[2:0] & wmask[2:0]);
            end
            irq_ff <= |(nxt_stat & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready             = awready_ff;
    assign wready              = wready_ff;
    assign bvalid              = bvalid_ff;
    assign bresp               = bresp_ff;
    assign arready             = arready_ff;
    assign rvalid              = rvalid_ff;
    assign rdata               = rdata_ff;
    assign rresp               = rresp_ff;
    assign main_osc_enable_pin = osc_en_ff;
    assign osc_bypass_pin      = osc_byp_ff;
    assign pll_prescale_out    = div_ff;
    assign pll_gain_out        = gain_ff;
    assign pll_clk_enable      = pll_en_ff;
    assign main_clk_select     = stable_ff;
    assign irq                 = irq_ff;

endmodule : main_osc_pll_clock_gen

// *** include/clk_gen_defs.svh ***
`ifndef CLK_GEN_DEFS_SVH
`define CLK_GEN_DEFS_SVH

// Register byte offsets.
`define OFS_OSC_CTRL    8'h00
`define OFS_FREQ_MEAS   8'h04
`define OFS_PLL_CFG     8'h08
`define OFS_PWR_STATUS  8'h0C
`define OFS_IRQ_STAT    8'h10
`define OFS_IRQ_MASK    8'h14

// Field positions.
`define OSC_EN_BIT      0
`define OSC_BYP_BIT     1
`define OSC_CNT_LSB     8
`define FREQ_DONE_BIT   16
`define PLL_DIV_LSB     0
`define PLL_SETTLE_LSB  8
`define PLL_GAIN_LSB    16
`define EVT_STABLE_BIT  0
`define EVT_LOCK_BIT    1
`define EVT_FREQ_BIT    2

// Reset values and counts.
`define RST_ZERO_WORD   32'h0000_0000
`define OSC_PRESCALE_MAX 3'h7
`define FREQ_LAST_FALL  5'h0F
`define AXI_RESP_OKAY   2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** include/clk_gen_pkg.sv ***
package clk_gen_pkg;

    // Frequency measurement sequence.
    typedef enum logic [1:0] {
        FQ_IDLE,
        FQ_ARM,
        FQ_COUNT,
        FQ_DONE
    } freq_st_e;

    typedef logic [7:0]  osc_count_t;
    typedef logic [7:0]  pll_div_t;
    typedef logic [10:0] pll_gain_t;
    typedef logic [5:0]  pll_settle_t;
    typedef logic [15:0] freq_count_t;
    typedef logic [2:0]  irq_vec_t;

endpackage : clk_gen_pkg

// *** tb/clk_gen_props.sv ***
`timescale 1ns/1ps
module clk_gen_props (
    // Clock and reset.
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes.
    input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [31:0] rdata,
    // Clock controls and interrupt.
    input wire logic        main_osc_enable_pin, main_clk_select, pll_clk_enable, irq,
    input wire logic [7:0]  pll_prescale_out,
    input wire logic [10:0] pll_gain_out
);
    ////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Reset must leave everything off, so this one is not disabled by reset.
    property p_rst;
        disable iff (1'b0) !aresetn |=> !main_osc_enable_pin && !main_clk_select
            && pll_prescale_out == 8'h00 && !pll_clk_enable && !irq;
    endproperty
    property p_div_off;
        (pll_prescale_out == 8'h00) [*2] |-> !pll_clk_enable;
    endproperty
    property p_gain_off;
        (pll_gain_out == 11'h000) [*2] |-> !pll_clk_enable;
    endproperty
    property p_pll_on;
        (pll_prescale_out != 8'h00 && pll_gain_out != 11'h000) [*2] |-> pll_clk_enable;
    endproperty
    property p_osc_off;
        (!main_osc_enable_pin) [*3] |-> !main_clk_select;
    endproperty
    property p_sel_rise;
        $rose(main_clk_select) |-> main_osc_enable_pin;
    endproperty
    property p_b_ans;
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
    endproperty
    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    property p_r_ans;
        arvalid && arready |-> ##[1:2] rvalid;
    endproperty
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
    a_div_off: assert property (p_div_off) else $error("pll on with zero divider");
    a_gain_off: assert property (p_gain_off) else $error("pll on with zero gain");
    a_pll_on: assert property (p_pll_on) else $error("pll off with valid setup");
    a_osc_off: assert property (p_osc_off) else $error("main clock kept when off");
    a_sel_rise: assert property (p_sel_rise) else $error("stable without enable");
    a_b_ans: assert property (p_b_ans) else $error("write response late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_ans: assert property (p_r_ans) else $error("read response late");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    c_stable: cover property ($rose(main_clk_select));
    c_pll: cover property ($rose(pll_clk_enable));
    c_irq: cover property ($rose(irq));
endmodule : clk_gen_props
bind main_osc_pll_clock_gen clk_gen_props props_u (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .main_osc_enable_pin(main_osc_enable_pin), .main_clk_select(main_clk_select),
    .pll_clk_enable(pll_clk_enable), .irq(irq), .pll_prescale_out(pll_prescale_out),
    .pll_gain_out(pll_gain_out));

// *** tb/clk_src_model.sv ***
`timescale 1ns/1ps
module clk_src_model #(
    parameter int SLOW_HALF = 100,
    parameter int MAIN_HALF = 20
) (
    // Oscillator request.
    input  wire logic osc_on,
    // Generated clocks.
    output logic      slow_clk,
    output logic      main_osc_clk
);
    ////////////////////////////////////////
    // The slow clock is the permanent clock, so it runs free.
    initial begin
        slow_clk = 1'b0;
        forever #(SLOW_HALF) slow_clk = ~slow_clk;
    end
    // The crystal or external source swings only while requested and rests low otherwise.
    initial begin
        main_osc_clk = 1'b0;
        #7;
        forever begin
            #(MAIN_HALF);
            main_osc_clk = osc_on ? ~main_osc_clk : 1'b0;
        end
    end
endmodule : clk_src_model

// *** tb/test_main_osc_pll_clock_gen.sv ***
`timescale 1ns/1ps
`include "clk_gen_defs.svh"
module test_main_osc_pll_clock_gen;
    localparam int SLOW_CYC = 40;
    localparam int RATIO    = 5;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, slow_clk, main_osc_clk, irq;
    logic        main_osc_enable_pin, osc_bypass_pin, pll_clk_enable, main_clk_select;
    logic [7:0]  awaddr, araddr, pll_prescale_out;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [10:0] pll_gain_out;
    int          failures, n_checks, cyc;
    ////////////////////////////////////////
    main_osc_pll_clock_gen dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .slow_clk, .main_osc_clk, .main_osc_enable_pin,
        .osc_bypass_pin, .pll_prescale_out, .pll_gain_out, .pll_clk_enable,
        .main_clk_select, .irq);
    clk_src_model model_u (.osc_on(main_osc_enable_pin | osc_bypass_pin), .slow_clk,
        .main_osc_clk);
    // Clock and a free cycle count for timing windows.
    initial aclk = 1'b0;
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Write and read release each channel only at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Ready follows the response by a cycle, so the slave must hold it.
        for (int t = 0; t < 64 && !got; t++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                got = 1'b1;
                resp = bresp;
            end else if (bvalid) begin
                bready <= 1'b1;
            end
        end
        bready <= 1'b0;
        chk(got, "no write response");
        repeat (2) @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        for (int t = 0; t < 64 && !got; t++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                got = 1'b1;
                rd_d = rdata;
                resp = rresp;
            end else if (rvalid) begin
                rready <= 1'b1;
            end
        end
        rready <= 1'b0;
        chk(got, "no read response");
    endtask : rd
    task automatic poll(input logic [7:0] a, input logic [31:0] m);
        rd_d = 32'h0000_0000;
        for (int i = 0; i < 600 && (rd_d & m) == 32'h0000_0000; i++)
            rd(a);
        chk((rd_d & m) != 32'h0000_0000, "flag never set");
    endtask : poll
    ////////////////////////////////////////
    task automatic t_reset();
        chk(main_osc_enable_pin === 1'b0 && main_clk_select === 1'b0, "osc on");
        chk(pll_prescale_out === 8'h00 && pll_clk_enable === 1'b0, "pll fed");
        for (int a = 0; a <= 20; a += 4) begin
            rd(8'(a));
            chk(rd_d === 32'h0000_0000 && irq === 1'b0, "reset value");
        end
    endtask : t_reset
    // Start-up twice, so a restart over a stable oscillator is seen to clear it.
    task automatic t_osc();
        int t0;
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        t0 = cyc;
        wr(`OFS_OSC_CTRL, 32'h0000_0201);
        rd(`OFS_PWR_STATUS);
        chk(rd_d[0] === 1'b0 && irq === 1'b0, "stable early");
        poll(`OFS_PWR_STATUS, 32'h0000_0001);
        chk(cyc - t0 >= 15 * SLOW_CYC && cyc - t0 <= 16 * SLOW_CYC + 20, "start-up");
        chk(irq === 1'b1 && main_clk_select === 1'b1, "no stable irq");
        poll(`OFS_FREQ_MEAS, 32'h0001_0000);
        chk(rd_d[15:0] >= 15*RATIO && rd_d[15:0] <= 16*RATIO + 1, "count");
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
        rd(`OFS_IRQ_STAT);
        chk(rd_d[2:0] === 3'h4 && irq === 1'b0, "clear or mask");
        wr(`OFS_OSC_CTRL, 32'h0000_0101);
        rd(`OFS_PWR_STATUS);
        chk(rd_d[0] === 1'b0, "restart kept stable");
        poll(`OFS_PWR_STATUS, 32'h0000_0001);
        wr(`OFS_OSC_CTRL, 32'h0000_0002);
        rd(`OFS_PWR_STATUS);
        chk(rd_d[0] === 1'b0 && main_clk_select === 1'b0, "stable when off");
        chk(osc_bypass_pin === 1'b1 && main_osc_enable_pin === 1'b0, "bypass");
    endtask : t_osc
    task automatic t_pll();
        logic [7:0] dv [4] = '{8'h01, 8'h02, 8'h80, 8'hFF};
        int t0;
        wr(`OFS_PLL_CFG, 32'h0005_0000);
        chk(pll_gain_out === 11'h005 && pll_clk_enable === 1'b0, "div zero");
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_PLL_CFG, {16'h0007, 8'h02, dv[i]});
            chk(pll_prescale_out === dv[i] && pll_clk_enable === 1'b1, "div");
        end
        wr(`OFS_IRQ_MASK, 32'h0000_0002);
        wr(`OFS_IRQ_STAT, 32'h0000_0007);
        t0 = cyc;
        wr(`OFS_PLL_CFG, 32'h0007_0304);
        rd(`OFS_PWR_STATUS);
        chk(rd_d[1] === 1'b0, "lock kept");
        poll(`OFS_PWR_STATUS, 32'h0000_0002);
        chk(cyc - t0 >= 2 * SLOW_CYC && cyc - t0 <= 4 * SLOW_CYC + 20, "settle");
        chk(irq === 1'b1, "no lock irq");
        wr(`OFS_PLL_CFG, 32'h0000_0304);
        chk(pll_clk_enable === 1'b0, "gain zero");
        wr(`OFS_PLL_CFG, 32'h0007_0304);
        rd(`OFS_PWR_STATUS);
        chk(rd_d[1] === 1'b0 && pll_clk_enable === 1'b1, "re-enable");
    endtask : t_pll
    task automatic t_bad();
        wr(8'h20, 32'hFFFF_FFFF);
        chk(resp === `AXI_RESP_SLVERR, "write resp");
        rd(8'h20);
        chk(resp === `AXI_RESP_SLVERR && rd_d === 32'h0000_0000, "read resp");
        // Only the second byte lane may change: the settle count alone moves.
        wstrb <= 4'h2;
        wr(`OFS_PLL_CFG, 32'h0000_0500);
        wstrb <= 4'hF;
        rd(`OFS_PLL_CFG);
        chk(rd_d === 32'h0007_0504, "byte strobe");
    endtask : t_bad
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // Main sequence; inputs get values at time zero, then move only on clock edges.
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        {failures, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_osc();
        t_pll();
        t_bad();
        final_report();
    end
    // A hang is cut short well beyond the few thousand cycles the run needs.
    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule : test_main_osc_pll_clock_gen
